//--- pkg/ptu_pkg.sv
package ptu_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0004;
  localparam logic [31:0] MASK_ADDR = 32'h0000_0008;
  // Control register field positions
  localparam int unsigned BANK_BIT = 0;
  localparam int unsigned EN_BIT = 1;
  localparam int unsigned IE_BIT = 2;
  localparam int unsigned ACK_BIT = 3;
  localparam int unsigned TAP_LSB = 4;
  localparam int unsigned PEND_BIT = 7;
  // Status and mask layout
  localparam int unsigned ROLL_BIT = 0;
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic MASK_RST = 1'b0;
  // Chain geometry: fixed front stages, selectable stages
  localparam int unsigned PRE_STAGES = 7;
  localparam int unsigned CHAIN_STAGES = 15;
  localparam int unsigned CNT_W = PRE_STAGES + CHAIN_STAGES;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Write channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } ptu_wr_type;
  // Whole state of the block
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] filt;
    logic [CNT_W-1:0] cnt;
    logic pend;
    logic ie;
    logic en;
    logic bank;
    logic [2:0] tap;
    logic stat;
    logic mask;
    logic irq;
    logic wake;
    ptu_wr_type wst;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ptu_state_type;
endpackage

//--- rtl/ptu_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] Fifteen chain stages, eight selectable taps
// [RULE2] Fixed divide-by-128 ahead of selectable stages
// [RULE3] External clock when enabled, else internal
// [RULE4] Counter held zero while disabled
// [RULE5] Rollover at chosen tap sets pending flag
// [RULE6] Interrupt when pending and enable both set
// [RULE7] Writing one to acknowledge clears flag
// [RULE8] Acknowledge bit stores nothing, reads zero
// [RULE9] First flag at half period, then full
// [RULE10] Bank zero ratios 32768 down to 8
// [RULE11] Bank one ratios 4194304 down to 1024
// [RULE12] Period is ratio over divider clock rate
// [RULE13] Software keeps tap fixed while enabled
// [RULE14] Reset clears enable and interrupt enable
// [RULE15] Disabling keeps pending flag unchanged
// [RULE16] Wait mode counts; register inaccessible
// [RULE17] Stop mode runs only with oscillator bit
// [RULE18] Stop without oscillator idles; no access
// [RULE19] Interrupt is a level, drops on clear
module ptu_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // AXI4-Lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // AXI4-Lite read
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [31:0] s_araddr,
  input wire logic [2:0] s_arprot,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // Divider clock sources, asynchronous pins
  input wire logic external_clock,
  input wire logic internal_clock,
  // Clock generator and power state
  input wire logic external_clock_on,
  input wire logic osc_run_in_stop,
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Requests to the core
  output logic irq,
  output logic wake_req
);

  // Registered and next state
  ptu_pkg::ptu_state_type st_q;
  ptu_pkg::ptu_state_type st_d;

  // Combinational helpers
  logic [1:0] rise;
  logic tick;
  logic run;
  logic hit;
  logic blocked;
  logic [ptu_pkg::CNT_W-1:0] cnt_n;
  logic [4:0] tap_n;
  logic got_aw;
  logic got_w;
  logic do_wr;
  logic ack_wr;
  logic ar_hs;
  logic [31:0] wa;
  logic [7:0] wd;
  logic ws;

  // Divider length for a tap, as a power of two
  function automatic logic [4:0] tap_log2(input logic bank,
                                          input logic [2:0] code);
    logic [4:0] b;
    b = 5'h0;
    case (code)
      3'h0: b = 5'hF;
      3'h1: b = 5'hD;
      3'h2: b = 5'hB;
      3'h3: b = 5'h7;
      3'h4: b = 5'h6;
      3'h5: b = 5'h5;
      3'h6: b = 5'h4;
      default: b = 5'h3;
    endcase
    // Bank one adds the fixed front stages
    if (bank) begin
      b = b + 5'(ptu_pkg::PRE_STAGES); // see [RULE2] see [RULE11]
    end
    return b;
  endfunction

  // Register index of an address; 2'h3 means unmapped
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a == ptu_pkg::CTRL_ADDR) begin
      s = 2'h0;
    end else if (a == ptu_pkg::STAT_ADDR) begin
      s = 2'h1;
    end else if (a == ptu_pkg::MASK_ADDR) begin
      s = 2'h2;
    end
    return s;
  endfunction

  // Output ports straight from flops
  assign s_awready = st_q.awready;
  assign s_wready = st_q.wready;
  assign s_bvalid = st_q.bvalid;
  assign s_bresp = st_q.bresp;
  assign s_arready = st_q.arready;
  assign s_rvalid = st_q.rvalid;
  assign s_rdata = st_q.rdata;
  assign s_rresp = st_q.rresp;
  assign irq = st_q.irq;
  assign wake_req = st_q.wake;

  // Next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    // Three-flop sync; filtered level moves on agreement
    st_d.sync1 = {external_clock, internal_clock};
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < 2; i++) begin
      if (st_q.sync2[i] == st_q.sync3[i]) begin
        st_d.filt[i] = st_q.sync3[i];
      end
    end
    rise = st_d.filt & ~st_q.filt;
    // Source choice ignores what clocks the bus
    tick = external_clock_on ? rise[1] : rise[0]; // see [RULE3]
    // Stop idles the chain unless the oscillator keeps going
    run = st_q.en & ~(stop_mode & ~osc_run_in_stop); // see [RULE17] see [RULE18]
    // Wait and stop lock the core out of the register
    blocked = wait_mode | stop_mode; // see [RULE16] see [RULE18]

    // Tap hit when the bit below the tap rises: half period first
    tap_n = tap_log2(st_q.bank, st_q.tap); // see [RULE10] see [RULE1]
    cnt_n = st_q.cnt + 1'b1;
    hit = (cnt_n & ((ptu_pkg::CNT_W'(1) << tap_n) - 1'b1)) ==
          (ptu_pkg::CNT_W'(1) << (tap_n - 5'h1)); // see [RULE9] see [RULE12]

    // Counter: cleared while off, frozen in an idle stop
    if (!st_q.en) begin
      st_d.cnt = '0; // see [RULE4]
    end else if (run && tick) begin
      st_d.cnt = cnt_n;
    end

    // Write: address and data may come in either order
    got_aw = st_q.aw_got | (s_awvalid & st_q.awready);
    got_w = st_q.w_got | (s_wvalid & st_q.wready);
    wa = st_q.aw_got ? st_q.awaddr : s_awaddr;
    wd = st_q.w_got ? st_q.wdata : s_wdata[7:0];
    ws = st_q.w_got ? st_q.wstrb0 : s_wstrb[0];
    do_wr = 1'b0;
    case (st_q.wst)
      ptu_pkg::WR_IDLE: begin
        st_d.aw_got = got_aw;
        st_d.w_got = got_w;
        st_d.awaddr = wa;
        st_d.wdata = wd;
        st_d.wstrb0 = ws;
        st_d.awready = ~got_aw;
        st_d.wready = ~got_w;
        if (got_aw && got_w) begin
          do_wr = 1'b1;
          st_d.aw_got = 1'b0;
          st_d.w_got = 1'b0;
          st_d.awready = 1'b0;
          st_d.wready = 1'b0;
          st_d.bvalid = 1'b1;
          // Locked-out or unmapped writes change nothing
          if (blocked || reg_sel(wa) == 2'h3) begin
            st_d.bresp = ptu_pkg::RESP_SLVERR;
          end else begin
            st_d.bresp = ptu_pkg::RESP_OKAY;
          end
          st_d.wst = ptu_pkg::WR_RESP;
        end
      end
      ptu_pkg::WR_RESP: begin
        // Hold response until taken, then rearm
        if (s_bready) begin
          st_d.bvalid = 1'b0;
          st_d.awready = 1'b1;
          st_d.wready = 1'b1;
          st_d.wst = ptu_pkg::WR_IDLE;
        end
      end
      default: begin
        st_d.wst = ptu_pkg::WR_IDLE;
        st_d.bvalid = 1'b0;
      end
    endcase
    do_wr = do_wr & ~blocked & ws;

    // Register updates from a write
    ack_wr = 1'b0;
    if (do_wr && reg_sel(wa) == 2'h0) begin
      st_d.bank = wd[ptu_pkg::BANK_BIT];
      st_d.en = wd[ptu_pkg::EN_BIT];
      st_d.ie = wd[ptu_pkg::IE_BIT];
      // Tap stays software's duty to keep still while on
      st_d.tap = wd[ptu_pkg::TAP_LSB +: 3]; // see [RULE13]
      ack_wr = wd[ptu_pkg::ACK_BIT]; // see [RULE7]
    end
    if (do_wr && reg_sel(wa) == 2'h2) begin
      st_d.mask = wd[ptu_pkg::ROLL_BIT];
    end

    // Read channel: answer one cycle after the address
    ar_hs = s_arvalid & st_q.arready;
    if (ar_hs) begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rdata = 32'h0000_0000;
      st_d.rresp = ptu_pkg::RESP_OKAY;
      if (blocked || reg_sel(s_araddr) == 2'h3) begin
        st_d.rresp = ptu_pkg::RESP_SLVERR;
      end else begin
        case (reg_sel(s_araddr))
          2'h0: begin
            // Acknowledge position left at zero
            st_d.rdata[ptu_pkg::PEND_BIT] = st_q.pend; // see [RULE8]
            st_d.rdata[ptu_pkg::TAP_LSB +: 3] = st_q.tap;
            st_d.rdata[ptu_pkg::IE_BIT] = st_q.ie;
            st_d.rdata[ptu_pkg::EN_BIT] = st_q.en;
            st_d.rdata[ptu_pkg::BANK_BIT] = st_q.bank;
          end
          2'h1: begin
            st_d.rdata[ptu_pkg::ROLL_BIT] = st_q.stat;
            st_d.stat = 1'b0;
          end
          default: begin
            st_d.rdata[ptu_pkg::ROLL_BIT] = st_q.mask;
          end
        endcase
      end
    end else if (st_q.rvalid && s_rready) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end else if (!st_q.rvalid) begin
      st_d.arready = 1'b1;
    end

    // Pending flag: set beats acknowledge; disabling does not clear it
    if (ack_wr) begin
      st_d.pend = 1'b0; // see [RULE15]
    end
    if (run && tick && hit) begin
      st_d.pend = 1'b1; // see [RULE5]
      st_d.stat = 1'b1;
    end

    // Level request from the next state
    st_d.irq = (st_d.pend & st_d.ie) |
               (st_d.stat & st_d.mask); // see [RULE6] see [RULE19]
    // Flag in stop wakes the core
    st_d.wake = st_d.pend & stop_mode; // see [RULE17]
  end

  // State register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0; // see [RULE14]
      st_q.wst <= ptu_pkg::WR_IDLE;
      st_q.bank <= ptu_pkg::CTRL_RST[ptu_pkg::BANK_BIT];
      st_q.mask <= ptu_pkg::MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Steps of a bus write
  sequence s_wr_take;
    st_q.wst == ptu_pkg::WR_IDLE && s_awvalid && st_q.awready &&
      s_wvalid && st_q.wready;
  endsequence
  sequence s_wr_resp;
    ##1 st_q.bvalid;
  endsequence

  // Disabled counter reads zero next cycle
  a_cnt_held_zero: assert property ( // see [RULE4]
    @(posedge aclk) disable iff (!aresetn)
    !st_q.en |=> st_q.cnt == '0)
    else $error("counter not held at zero while disabled");

  // Tap hit raises the pending flag
  a_flag_on_tap: assert property ( // see [RULE5]
    @(posedge aclk) disable iff (!aresetn)
    run && tick && hit |=> st_q.pend)
    else $error("rollover did not set pending flag");

  // Request follows flag and enable one cycle later
  a_irq_follows: assert property ( // see [RULE6]
    @(posedge aclk) disable iff (!aresetn)
    ##1 irq == ($past(st_d.pend) & $past(st_d.ie) |
                $past(st_d.stat) & $past(st_d.mask)))
    else $error("interrupt level does not match flag and enable");

  // Acknowledge clears unless a hit coincides
  a_ack_clears: assert property ( // see [RULE7]
    @(posedge aclk) disable iff (!aresetn)
    ack_wr && !(run && tick && hit) |=> !st_q.pend)
    else $error("acknowledge did not clear pending flag");

  // With the status path masked, an acknowledge drops the request
  a_irq_drop: assert property ( // see [RULE19]
    @(posedge aclk) disable iff (!aresetn)
    ack_wr && !(run && tick && hit) && !st_q.mask |=> !irq)
    else $error("interrupt stayed up after acknowledge");

  // Acknowledge bit reads zero
  a_ack_zero: assert property ( // see [RULE8]
    @(posedge aclk) disable iff (!aresetn)
    s_rvalid |-> !s_rdata[ptu_pkg::ACK_BIT])
    else $error("acknowledge bit read as one");

  // Disabling leaves the flag alone; a coinciding ack or hit may move it
  a_off_keeps: assert property ( // see [RULE15]
    @(posedge aclk) disable iff (!aresetn)
    $fell(st_q.en) && !$past(ack_wr) && !$past(run && tick && hit) |->
      st_q.pend == $past(st_q.pend))
    else $error("disable changed pending flag");

  // Locked-out write answers with an error
  a_lock_resp: assert property ( // see [RULE16]
    @(posedge aclk) disable iff (!aresetn)
    s_wr_take ##0 blocked |-> s_wr_resp ##0
      st_q.bresp == ptu_pkg::RESP_SLVERR)
    else $error("write accepted while core locked out");

  // Locked-out read answers zero with an error
  a_lock_read: assert property ( // see [RULE16] see [RULE18]
    @(posedge aclk) disable iff (!aresetn)
    s_arvalid && st_q.arready && blocked |=>
      st_q.rvalid && st_q.rresp == ptu_pkg::RESP_SLVERR && st_q.rdata == '0)
    else $error("read answered while core locked out");

  // Idle stop freezes the counter
  a_stop_frozen: assert property ( // see [RULE18]
    @(posedge aclk) disable iff (!aresetn)
    stop_mode && !osc_run_in_stop && st_q.en |=> $stable(st_q.cnt))
    else $error("counter moved in idle stop");

  // Wake request only follows a cycle spent in stop mode
  a_wake_stop: assert property ( // see [RULE17]
    @(posedge aclk) disable iff (!aresetn)
    !stop_mode |=> !wake_req)
    else $error("wake request outside stop");

  // Reset clears both enables; no history needed at the first edge
  a_reset_clear: assert property ( // see [RULE14]
    @(posedge aclk)
    !aresetn |=> !st_q.en && !st_q.ie)
    else $error("enables not cleared by reset");

  // Write response one cycle after both channels are taken together
  a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_take |-> s_wr_resp)
    else $error("write response late");

endmodule // ptu_top

//--- tb/periodic_timebase_interrupt_test.sv
`timescale 1ns/100ps
// Bench compare: counts every check, reports a mismatch at once
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module periodic_timebase_interrupt_test;
  // Clock and reset
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  // Bus master side
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  // Clock sources, bit 1 external, bit 0 internal; idle low between ticks
  logic [1:0] pins = 2'h0;
  logic external_clock_on = 1'b0, osc_run_in_stop = 1'b0;
  logic wait_mode = 1'b0, stop_mode = 1'b0;
  logic irq, wake_req;
  // Bookkeeping
  int error_cnt = 0;
  int num_checks = 0;
  logic [1:0] rs;
  logic [31:0] rd;
  // Divide ratios by bank and tap code
  int tbl [2][8] = '{'{32768, 8192, 2048, 128, 64, 32, 16, 8},
    '{4194304, 1048576, 262144, 16384, 8192, 4096, 2048, 1024}};

  // Prot fields are ignored by the block, so tied off
  ptu_top dut (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr,
    .s_awprot(3'h0), .s_wvalid, .s_wready, .s_wdata, .s_wstrb, .s_bvalid,
    .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
    .s_arprot(3'h0), .s_rvalid, .s_rready, .s_rdata, .s_rresp,
    .external_clock(pins[1]), .internal_clock(pins[0]), .external_clock_on,
    .osc_run_in_stop, .wait_mode, .stop_mode, .irq, .wake_req);

  // Free running bus clock
  always #4 aclk = ~aclk;

  // Control byte from flags {ack, ie, en, bank} and tap code
  function automatic logic [7:0] ctl(input logic [3:0] f,
      input logic [2:0] t);
    return {1'b0, t, f};
  endfunction

  // One write; both channels offered together, released as taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
      input logic [3:0] st = 4'hF);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= {24'h0, d};
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    // No cycle budget: only the watchdog ends a stuck handshake
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_awready === 1'b1) begin
        ad = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!wd && s_wready === 1'b1) begin
        wd = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
    // Let side effects reach the outputs before anyone looks
    repeat (2) @(posedge aclk);
  endtask

  // One read; data and response taken at the rvalid edge
  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // Divider ticks on one pin, slow enough for the input filter
  task automatic pulse(input bit ext, input int n);
    repeat (n) begin
      @(posedge aclk);
      pins[ext] <= 1'b1;
      repeat (4) @(posedge aclk);
      pins[ext] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    // Sync latency plus flag and request flops
    repeat (8) @(posedge aclk);
  endtask

  task automatic t_reset;
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("ctrl reset", 32'h0, rd)
    rdr(ptu_pkg::MASK_ADDR);
    `CHK("mask reset", 32'h0, rd)
    `CHK("irq reset", 1'b0, irq)
    // Byte lane 0 not strobed: write must be dropped
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h6, 3'h7), 4'hE);
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("no strobe", 32'h0, rd)
    rdr(32'h0000_000C);
    `CHK("unmapped", ptu_pkg::RESP_SLVERR, rs)
    $display("test reset done");
  endtask

  // Half period to first flag, full period after acknowledge
  task automatic t_rate(input logic b, input logic [2:0] c);
    int r;
    r = tbl[b][c];
    wr(ptu_pkg::CTRL_ADDR, ctl({3'b011, b}, c));
    pulse(0, r / 2 - 1);
    `CHK("early", 1'b0, irq)
    pulse(0, 1);
    `CHK("half", 1'b1, irq)
    wr(ptu_pkg::CTRL_ADDR, ctl({3'b111, b}, c));
    `CHK("ack", 1'b0, irq)
    pulse(0, r - 1);
    `CHK("pre", 1'b0, irq)
    pulse(0, 1);
    `CHK("full", 1'b1, irq)
    // Disable first so the next tap change is made while stopped
    wr(ptu_pkg::CTRL_ADDR, ctl({3'b110, b}, c));
  endtask

  task automatic t_flag;
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h2, 3'h7));
    pulse(0, 4);
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("pend", 32'hF2, rd)
    `CHK("irq masked", 1'b0, irq)
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h6, 3'h7));
    `CHK("irq on", 1'b1, irq)
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h0, 3'h7));
    `CHK("irq drop", 1'b0, irq)
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("kept", 32'hF0, rd)
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h8, 3'h7));
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("cleared", 32'h70, rd)
    // Ticks while disabled must not advance the chain
    pulse(0, 10);
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h2, 3'h7));
    pulse(0, 3);
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("held", 32'h72, rd)
    pulse(0, 1);
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("restart", 32'hF2, rd)
    $display("test flag done");
  endtask

  // Sticky status cleared by read, masked onto the request line
  task automatic t_stat;
    rdr(ptu_pkg::STAT_ADDR);
    `CHK("stat set", 32'h1, rd)
    rdr(ptu_pkg::STAT_ADDR);
    `CHK("stat clr", 32'h0, rd)
    wr(ptu_pkg::MASK_ADDR, 8'h01);
    wr(ptu_pkg::CTRL_ADDR, ctl(4'hA, 3'h7));
    `CHK("irq idle", 1'b0, irq)
    pulse(0, 8);
    `CHK("irq stat", 1'b1, irq)
    rdr(ptu_pkg::STAT_ADDR);
    `CHK("irq gone", 1'b0, irq)
    wr(ptu_pkg::MASK_ADDR, 8'h00);
    rdr(ptu_pkg::MASK_ADDR);
    `CHK("mask off", 32'h0, rd)
    $display("test status done");
  endtask

  task automatic t_low;
    wr(ptu_pkg::CTRL_ADDR, ctl(4'hA, 3'h7));
    wait_mode <= 1'b1;
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h0, 3'h0));
    `CHK("wait wr", ptu_pkg::RESP_SLVERR, rs)
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("wait rd", 32'h0, rd)
    pulse(0, 8);
    wait_mode <= 1'b0;
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("wait run", 32'hF2, rd)
    wr(ptu_pkg::CTRL_ADDR, ctl(4'hA, 3'h7));
    stop_mode <= 1'b1;
    pulse(0, 16);
    `CHK("no wake", 1'b0, wake_req)
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("stop rd", ptu_pkg::RESP_SLVERR, rs)
    osc_run_in_stop <= 1'b1;
    pulse(0, 8);
    `CHK("wake", 1'b1, wake_req)
    stop_mode <= 1'b0;
    osc_run_in_stop <= 1'b0;
    $display("test low power done");
  endtask

  // External source selected: internal ticks must be ignored
  task automatic t_ext;
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h8, 3'h7));
    external_clock_on <= 1'b1;
    wr(ptu_pkg::CTRL_ADDR, ctl(4'h2, 3'h7));
    pulse(0, 16);
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("int ignored", 32'h72, rd)
    pulse(1, 4);
    rdr(ptu_pkg::CTRL_ADDR);
    `CHK("ext counted", 32'hF2, rd)
    external_clock_on <= 1'b0;
    $display("test external done");
  endtask

  // Single exit point of the run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    for (int c = 2; c < 8; c++) t_rate(1'b0, c[2:0]);
    t_rate(1'b1, 3'h7);
    $display("test rates done");
    t_flag();
    t_stat();
    t_low();
    t_ext();
    tally_and_finish();
  end

  // Watchdog, well above the roughly 41k cycles the tests need
  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule // periodic_timebase_interrupt_test
